// ===== core/shpio_core.sv
// Script signal interface, two-pass sequencing and solenoid stage control.
// Assumes a Wishbone classic master, converter words on core_clk, async pins.
// Notes on behaviour
// - Logical outputs are on at 1.0 or more
// - Channel drives only with enable and nonzero level
// - Level 100.0 gives nominal current, range clamped
// - Negative B level drives secondary B, own enable
// - Enabled driven outputs are watched for wire break
// - Wire break on active output drops ready
// - Fault request at 1.0 raises script error
// - Script error drops ready, stage outputs off
// - Script error latched until policy clears it
// - First pass, lines 26-30, algorithm, then rest
// - Single-ended inputs shown as -5.0 to 105.0, from 0.0 for input 3 and in current range
// - Differential input shown as -105.0 to 105.0
// - Switch and status flags shown as 0.0/1.0
// - Analog outputs taken over 0.0 to 100.0, output 2 over -100.0 to 100.0
// - Channel A level taken over 0.0 to 100.0
// - Channel B level over -100.0 to 100.0
// - Blink toggles only with error and release
// - Secondary B enable defaults unassigned, off
// - Valve drive signed, relief and inverter positive
// - Capture value at 1.0 snapshots script values
// - Processing time per cycle exposed in us
// - Default green lamp: steady ready, blink on error
module shpio_core
  import shpio_pkg::*;
#(
  parameter int NUM_LINES = 40,
  parameter int CYC_PERIOD = CYCLE_CYC,
  parameter int BLINK_HALF = BLINK_HALF_CYC,
  parameter logic [15:0] NOM_CURRENT = NOM_CURRENT_RST
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire shpio_val_t [4:0] anaIn,
  input wire logic [2:0] rangeCurrent,
  input wire logic [4:0] switchPin,
  input wire logic [2:0] wireBreakPin,
  input wire logic algoDone,
  input wire logic inPosStatus,
  output shpio_algo_t algo,
  output logic algoStart,
  output shpio_stage_t stage,
  output shpio_lamps_t lamps,
  output shpio_val_t [4:0] anaOut,
  output logic ready,
  output logic captureTrig,
  output logic [15:0] cycleTimeUs
);
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    shpio_val_t [NUM_OUT-1:0] outv;
    shpio_phase_t ph;
    logic [5:0] line;
    logic [31:0] cycCnt;
    logic [7:0] usDiv;
    logic [15:0] usCnt;
    logic [15:0] dt;
    shpio_algo_t algo;
    logic algoStart;
    shpio_stage_t stage;
    shpio_lamps_t lamps;
    shpio_val_t [4:0] anaOut;
    logic [1:0] policy;
    logic lampDefault;
    logic [4:0] divider;
    logic faultReq;
    logic relOn;
    logic relPrev;
    logic scriptErr;
    logic [2:0] wbErr;
    logic ready;
    logic blink;
    logic [31:0] blinkCnt;
    logic [7:0] sync1;
    logic [7:0] sync2;
    shpio_val_t [NUM_IN-1:0] inVal;
    shpio_val_t [3:0] capture_trigger;
    logic capture;
  } shpio_state_t;

  shpio_state_t s;
  shpio_state_t next_;
  shpio_val_t [NUM_LIM-1:0] limIn;
  shpio_val_t [NUM_LIM-1:0] limLo;
  shpio_val_t [NUM_LIM-1:0] limHi;
  shpio_val_t [NUM_LIM-1:0] limRes;
  logic [9:0] wordIdx;
  logic [9:0] inOff;
  logic [9:0] snapOff;
  logic busReq;
  logic clrCond;
  logic commitP2;
  logic errNow;
  logic [2:0] wbDet;

  assign wordIdx = wb_adr_i[11:2];
  assign inOff = wordIdx - ADDR_IN_BASE[11:2];
  assign snapOff = wordIdx - ADDR_CAPTURE_TRIGGER_BASE[11:2];
  assign busReq = wb_cyc_i && wb_stb_i && !s.ack;
  assign commitP2 = (s.ph == PH_PASS2) && (s.line == 6'(NUM_LINES - 1));
  assign errNow = (|s.wbErr) || s.scriptErr;
  assign wbDet = {s.stage.bSecOn, s.stage.bPriOn, s.stage.aOn} & s.sync2[7:5];

  function automatic logic isOn(input shpio_val_t v);
    return v >= ON_THRESH;
  endfunction

  function automatic logic [15:0] scale(input shpio_val_t v);
    logic [31:0] p;
    p = 32'(unsigned'(v)) * 32'(NOM_CURRENT);
    return 16'(p / 32'(FULL_SCALE));
  endfunction

  // Limiter table: inputs first, then script output values
  always_comb begin
    for (int k = 0; k < 3; k++) begin
      limIn[k] = anaIn[k];
      limLo[k] = rangeCurrent[k] ? ZERO : SE_MIN;
      limHi[k] = SE_MAX;
    end
    limIn[3] = anaIn[3];
    limLo[3] = ZERO;
    limHi[3] = SE_MAX;
    limIn[4] = anaIn[4];
    limLo[4] = DIF_MIN;
    limHi[4] = SE_MAX;
    limIn[5] = s.outv[IDX_A_LEVEL];
    limLo[5] = ZERO;
    limHi[5] = FULL_SCALE;
    limIn[6] = s.outv[IDX_B_LEVEL];
    limLo[6] = NEG_FULL;
    limHi[6] = FULL_SCALE;
    for (int k = 0; k < 5; k++) begin
      limIn[7+k] = s.outv[IDX_ANA_OUT0+k];
      limLo[7+k] = (k == 2) ? NEG_FULL : ZERO;
      limHi[7+k] = FULL_SCALE;
    end
  end

  for (genvar g = 0; g < NUM_LIM; g++) begin : gLim
    shpio_limit uLim (
      .val(limIn[g]),
      .lo(limLo[g]),
      .hi(limHi[g]),
      .res(limRes[g])
    );
  end

  always_comb begin
    logic [4:0] d;
    logic errNext;
    d = '0;
    errNext = 1'b0;
    next_ = s;
    next_.ack = busReq;
    next_.rdat = '0;
    next_.capture = 1'b0;
    next_.algoStart = 1'b0;
    next_.sync1 = {wireBreakPin, switchPin};
    next_.sync2 = s.sync1;
    if (busReq && wb_we_i) begin
      if (wordIdx < 10'(NUM_OUT)) begin
        if (wb_sel_i[0]) next_.outv[wordIdx[4:0]][7:0] = wb_dat_i[7:0];
        if (wb_sel_i[1]) next_.outv[wordIdx[4:0]][15:8] = wb_dat_i[15:8];
      end else if ({wordIdx, 2'b00} == ADDR_CTRL) begin
        if (wb_sel_i[0]) begin
          next_.policy = wb_dat_i[CTRL_POLICY_LSB+:2];
          next_.lampDefault = wb_dat_i[CTRL_LAMPDEF_BIT];
        end
        if (wb_sel_i[1]) begin
          d = wb_dat_i[CTRL_DIV_LSB+:5];
          // Above line 26 the M lines would overlap pass one
          next_.divider = (d > DIV_MAX) ? DIV_MAX : d;
        end
      end
    end else if (busReq) begin
      if (wordIdx < 10'(NUM_OUT)) begin
        next_.rdat = {{16{1'b0}}, s.outv[wordIdx[4:0]]};
      end else if (wordIdx >= ADDR_IN_BASE[11:2] && inOff < 10'(NUM_IN)) begin
        next_.rdat = {{16{1'b0}}, s.inVal[inOff[3:0]]};
      end else if ({wordIdx, 2'b00} == ADDR_CTRL) begin
        next_.rdat[CTRL_POLICY_LSB+:2] = s.policy;
        next_.rdat[CTRL_LAMPDEF_BIT] = s.lampDefault;
        next_.rdat[CTRL_DIV_LSB+:5] = s.divider;
      end else if ({wordIdx, 2'b00} == ADDR_STAT) begin
        next_.rdat[STAT_READY_BIT] = s.ready;
        next_.rdat[STAT_SCRIPT_FAULT_REQUEST_BIT] = s.scriptErr;
        next_.rdat[STAT_WB_LSB+:3] = s.wbErr;
        next_.rdat[STAT_BLINK_BIT] = s.blink;
      end else if ({wordIdx, 2'b00} == ADDR_DT) begin
        next_.rdat[15:0] = s.dt;
      end else if (wordIdx >= ADDR_CAPTURE_TRIGGER_BASE[11:2] && snapOff < 10'h004) begin
        next_.rdat = {{16{1'b0}}, s.capture_trigger[snapOff[1:0]]};
      end
    end

    // Processing cycle sequencer
    next_.cycCnt = (s.cycCnt == 32'(CYC_PERIOD - 1)) ? '0 : s.cycCnt + 32'h0000_0001;
    if (s.ph != PH_IDLE) begin
      if (s.usDiv == 8'(US_CYC - 1)) begin
        next_.usDiv = '0;
        next_.usCnt = s.usCnt + 16'h0001;
      end else begin
        next_.usDiv = s.usDiv + 8'h01;
      end
    end
    unique case (s.ph)
      PH_IDLE: begin
        if (s.cycCnt == 32'(CYC_PERIOD - 1)) begin
          next_.ph = PH_PASS1;
          next_.line = (s.divider == 5'h00) ? LINE_M_FIRST : 6'h00;
          next_.usDiv = '0;
          next_.usCnt = '0;
        end
      end
      PH_PASS1: begin
        if (s.line == LINE_M_LAST) begin
          next_.algo.target = s.outv[IDX_TARGET];
          next_.algo.speed = s.outv[IDX_SPEED];
          next_.algo.rawPos = s.outv[IDX_RAW_POS];
          next_.algo.loopRelease = isOn(s.outv[IDX_LOOP_RELEASE]);
          next_.algo.moveStart = isOn(s.outv[IDX_MOVE_START]);
          next_.algo.jogA = isOn(s.outv[IDX_JOG_A]);
          next_.algo.jogB = isOn(s.outv[IDX_JOG_B]);
          next_.ph = PH_ALGO;
          next_.algoStart = 1'b1;
        end else if (s.line + 6'h01 == {1'b0, s.divider}) begin
          next_.line = LINE_M_FIRST;
        end else begin
          next_.line = s.line + 6'h01;
        end
      end
      PH_ALGO: begin
        if (algoDone) begin
          next_.ph = PH_PASS2;
          next_.line = ({1'b0, s.divider} == LINE_M_FIRST) ? LINE_M_LAST + 6'h01
                                                           : {1'b0, s.divider};
        end
      end
      PH_PASS2: begin
        if (commitP2) begin
          next_.ph = PH_IDLE;
          next_.dt = s.usCnt;
          next_.lamps.sw1 = isOn(s.outv[IDX_SW1]);
          next_.lamps.sw2 = isOn(s.outv[IDX_SW2]);
          next_.lamps.midYellow = isOn(s.outv[IDX_MID_YELLOW]);
          next_.lamps.rightYellow = isOn(s.outv[IDX_RIGHT_YELLOW]);
          next_.lamps.green = s.lampDefault ? (s.ready || s.blink)
                                            : isOn(s.outv[IDX_GREEN]);
          next_.relOn = isOn(s.outv[IDX_EXT_RELEASE]);
          next_.faultReq = isOn(s.outv[IDX_FAULT_REQ]);
          for (int k = 0; k < 5; k++) next_.anaOut[k] = limRes[7+k];
          next_.stage.aOn = isOn(s.outv[IDX_A_EN]) && limRes[5] > ZERO;
          next_.stage.aCur = next_.stage.aOn ? scale(limRes[5]) : '0;
          next_.stage.bPriOn = isOn(s.outv[IDX_B1_EN]) && limRes[6] > ZERO;
          next_.stage.bPriCur = next_.stage.bPriOn ? scale(limRes[6]) : '0;
          // Reset value 0 keeps the secondary off for negative levels
          next_.stage.bSecOn = isOn(s.outv[IDX_B2_EN]) && limRes[6] < ZERO;
          next_.stage.bSecCur = next_.stage.bSecOn ? scale(-limRes[6]) : '0;
          if (isOn(s.outv[IDX_CAPTURE])) begin
            next_.capture = 1'b1;
            next_.capture_trigger = {s.outv[IDX_RAW_POS], s.outv[IDX_TARGET],
                          s.outv[IDX_B_LEVEL], s.outv[IDX_A_LEVEL]};
          end
        end else begin
          next_.line = (s.line + 6'h01 == LINE_M_FIRST) ? LINE_M_LAST + 6'h01
                                                        : s.line + 6'h01;
        end
      end
    endcase

    // Fault latches; a set in the clear cycle wins
    next_.relPrev = s.relOn;
    if (s.policy != POL_OFF) begin
      next_.wbErr = (s.wbErr & ~({3{clrCond}} & ~wbDet)) | wbDet;
      next_.scriptErr = (s.scriptErr && !(clrCond && !s.faultReq))
                        || s.faultReq;
    end else begin
      next_.wbErr = '0;
      next_.scriptErr = 1'b0;
    end
    errNext = (|next_.wbErr) || next_.scriptErr;
    next_.ready = s.relOn && !errNext;
    if (errNext) next_.stage = '0;
    if (errNow && s.relOn) begin
      if (s.blinkCnt >= 32'(BLINK_HALF - 1)) begin
        next_.blinkCnt = '0;
        next_.blink = !s.blink;
      end else begin
        next_.blinkCnt = s.blinkCnt + 32'h0000_0001;
      end
    end else begin
      next_.blinkCnt = '0;
      next_.blink = 1'b0;
    end
    for (int k = 0; k < 5; k++) next_.inVal[k] = limRes[k];
    for (int k = 0; k < 5; k++) next_.inVal[5+k] = s.sync2[k] ? ON_VALUE : ZERO;
    next_.inVal[10] = s.ready ? ON_VALUE : ZERO;
    next_.inVal[11] = s.blink ? ON_VALUE : ZERO;
    next_.inVal[12] = inPosStatus ? ON_VALUE : ZERO;
  end

  // Clear condition per fault policy
  always_comb begin
    unique case (s.policy)
      POL_ON: clrCond = (busReq && wb_we_i && {wordIdx, 2'b00} == ADDR_CTRL && wb_sel_i[2]
                         && wb_dat_i[CTRL_CLR_BIT]) || (s.relOn && !s.relPrev);
      POL_AUTO: clrCond = 1'b1;
      default: clrCond = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.policy <= POLICY_RST;
      s.divider <= DIV_RST;
      s.lampDefault <= LAMPDEF_RST;
    end else begin
      s <= next_;
    end
  end

  assign wb_dat_o = s.rdat;
  assign wb_ack_o = s.ack;
  assign algo = s.algo;
  assign algoStart = s.algoStart;
  assign stage = s.stage;
  assign lamps = s.lamps;
  assign anaOut = s.anaOut;
  assign ready = s.ready;
  assign captureTrig = s.capture;
  assign cycleTimeUs = s.dt;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  property p_thresh;
    commitP2 && s.outv[IDX_SW1] < ON_THRESH |=> !s.lamps.sw1;
  endproperty
  a_thresh: assert property (p_thresh) else $error("switch output on below 1.0");
  property p_gate;
    s.stage.aCur != 16'h0000 |-> s.stage.aOn;
  endproperty
  a_gate: assert property (p_gate) else $error("channel A current without enable");
  property p_scale;
    commitP2 && s.outv[IDX_A_LEVEL] > FULL_SCALE && isOn(s.outv[IDX_A_EN]) && !errNow
      && wbDet == 3'b000 && !s.faultReq |=> s.stage.aCur == NOM_CURRENT;
  endproperty
  a_scale: assert property (p_scale) else $error("level above range not clamped");
  property p_bsplit;
    s.stage.bSecOn |-> !s.stage.bPriOn && s.stage.bSecCur != 16'h0000;
  endproperty
  a_bsplit: assert property (p_bsplit) else $error("both B outputs active");
  property p_wire;
    s.stage.aOn && s.sync2[5] && s.policy != POL_OFF |=> s.wbErr[0] && !s.ready && !s.stage.aOn;
  endproperty
  a_wire: assert property (p_wire) else $error("wire break did not shut down");
  property p_script;
    s.faultReq && s.policy != POL_OFF |=> s.scriptErr && !s.ready;
  endproperty
  a_script: assert property (p_script) else $error("fault request not raised");
  property p_latch;
    s.scriptErr && s.policy == POL_ON && !clrCond |=> s.scriptErr;
  endproperty
  a_latch: assert property (p_latch) else $error("script error dropped early");
  property p_order;
    $rose(s.ph == PH_ALGO) |-> $past(s.line) == LINE_M_LAST;
  endproperty
  a_order: assert property (p_order) else $error("algorithm before M lines");
  property p_ascend;
    s.ph == PH_PASS2 && $past(s.ph) == PH_PASS2 |-> s.line > $past(s.line);
  endproperty
  a_ascend: assert property (p_ascend) else $error("lines not ascending");
  property p_blink;
    !(errNow && s.relOn) |=> !s.blink;
  endproperty
  a_blink: assert property (p_blink) else $error("blink without error");
  property p_flag;
    s.inVal[5] == ZERO || s.inVal[5] == ON_VALUE;
  endproperty
  a_flag: assert property (p_flag) else $error("switch flag not 0.0 or 1.0");
  property p_range;
    s.inVal[0] >= SE_MIN && s.inVal[0] <= SE_MAX;
  endproperty
  a_range: assert property (p_range) else $error("input out of presented range");
  property p_capture_trigger;
    commitP2 && isOn(s.outv[IDX_CAPTURE]) |=> s.capture ##1 !s.capture;
  endproperty
  a_capture_trigger: assert property (p_capture_trigger) else $error("capture not taken");

  c_wire: cover property (s.wbErr != 3'b000);
  c_script: cover property (s.scriptErr ##1 !s.faultReq);
  c_sec: cover property (s.stage.bSecOn);
  c_cycle: cover property (s.ph == PH_PASS2 ##1 s.ph == PH_IDLE);
endmodule // shpio_core

// ===== core/shpio_limit.sv
// Signal limiter: clamps a signed value into [lo, hi].
// Assumes lo is not above hi.
module shpio_limit
  import shpio_pkg::*;
(
  input wire shpio_val_t val,
  input wire shpio_val_t lo,
  input wire shpio_val_t hi,
  output shpio_val_t res
);
  assign res = (val < lo) ? lo : ((val > hi) ? hi : val);
endmodule // shpio_limit

// ===== core/shpio_pkg.sv
// Package of the script signal interface and output stage control.
// Assumes one 125 MHz core clock; values are signed 0.1 % units.
package shpio_pkg;
  typedef logic signed [15:0] shpio_val_t;

  // Value scale: 16'h000a is 1.0, 16'h03e8 is 100.0
  localparam shpio_val_t ZERO = 16'h0000;
  localparam shpio_val_t ON_THRESH = 16'h000a;
  localparam shpio_val_t ON_VALUE = 16'h000a;
  localparam shpio_val_t FULL_SCALE = 16'h03e8;
  localparam shpio_val_t NEG_FULL = 16'hfc18;
  localparam shpio_val_t SE_MIN = 16'hffce;
  localparam shpio_val_t SE_MAX = 16'h041a;
  localparam shpio_val_t DIF_MIN = 16'hfbe6;

  // Script output value slots, word index at ADDR_OUT_BASE
  localparam int IDX_LOOP_RELEASE = 0;
  localparam int IDX_MOVE_START = 1;
  localparam int IDX_JOG_A = 2;
  localparam int IDX_JOG_B = 3;
  localparam int IDX_SW1 = 4;
  localparam int IDX_SW2 = 5;
  localparam int IDX_GREEN = 6;
  localparam int IDX_MID_YELLOW = 7;
  localparam int IDX_RIGHT_YELLOW = 8;
  localparam int IDX_EXT_RELEASE = 9;
  localparam int IDX_CAPTURE = 10;
  localparam int IDX_A_EN = 11;
  localparam int IDX_B1_EN = 12;
  localparam int IDX_B2_EN = 13;
  localparam int IDX_FAULT_REQ = 14;
  localparam int IDX_A_LEVEL = 15;
  localparam int IDX_B_LEVEL = 16;
  localparam int IDX_TARGET = 17;
  localparam int IDX_SPEED = 18;
  localparam int IDX_RAW_POS = 19;
  localparam int IDX_ANA_OUT0 = 20;
  localparam int NUM_OUT = 25;
  localparam int NUM_IN = 13;
  localparam int NUM_LIM = 12;

  // Byte offsets
  localparam logic [11:0] ADDR_OUT_BASE = 12'h000;
  localparam logic [11:0] ADDR_IN_BASE = 12'h080;
  localparam logic [11:0] ADDR_CTRL = 12'h100;
  localparam logic [11:0] ADDR_STAT = 12'h104;
  localparam logic [11:0] ADDR_DT = 12'h108;
  localparam logic [11:0] ADDR_CAPTURE_TRIGGER_BASE = 12'h110;

  // Field positions
  localparam int CTRL_POLICY_LSB = 0;
  localparam int CTRL_LAMPDEF_BIT = 4;
  localparam int CTRL_DIV_LSB = 8;
  localparam int CTRL_CLR_BIT = 16;
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_SCRIPT_FAULT_REQUEST_BIT = 1;
  localparam int STAT_WB_LSB = 2;
  localparam int STAT_BLINK_BIT = 5;

  // Script line layout
  localparam logic [5:0] LINE_M_FIRST = 6'h1a;
  localparam logic [5:0] LINE_M_LAST = 6'h1e;
  localparam logic [4:0] DIV_MAX = 5'h1a;

  typedef enum logic [1:0] {
    POL_OFF = 2'b00,
    POL_ON = 2'b01,
    POL_AUTO = 2'b10
  } shpio_policy_t;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_PASS1 = 2'b01,
    PH_ALGO = 2'b10,
    PH_PASS2 = 2'b11
  } shpio_phase_t;

  // Reset values
  localparam logic [1:0] POLICY_RST = 2'b01;
  localparam logic [4:0] DIV_RST = 5'h0a;
  localparam logic LAMPDEF_RST = 1'b1;
  localparam logic [15:0] NOM_CURRENT_RST = 16'h03e8;

  // Timing
  localparam int CLK_MHZ = 125;
  localparam int US_CYC = CLK_MHZ;
  localparam int CYCLE_US = 1000;
  localparam int CYCLE_CYC = CYCLE_US * CLK_MHZ;
  localparam int BLINK_HALF_MS = 250;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * 1000 * CLK_MHZ;

  typedef struct packed {
    shpio_val_t target;
    shpio_val_t speed;
    shpio_val_t rawPos;
    logic loopRelease;
    logic moveStart;
    logic jogA;
    logic jogB;
  } shpio_algo_t;

  typedef struct packed {
    logic aOn;
    logic bPriOn;
    logic bSecOn;
    logic [15:0] aCur;
    logic [15:0] bPriCur;
    logic [15:0] bSecCur;
  } shpio_stage_t;

  typedef struct packed {
    logic green;
    logic midYellow;
    logic rightYellow;
    logic sw1;
    logic sw2;
  } shpio_lamps_t;
endpackage

// ===== verification/shpio_algo_model.sv
// Stand-in for the positioning core: one done pulse per start pulse.
// Assumes one clock; lag sets how many cycles the answer takes.
module shpio_algo_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic algoStart,
  input wire logic [5:0] lag,
  output logic algoDone
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] cnt;
  logic busy;
  // Pulse, not level: a stale level would end the next wait early
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 6'h00;
      busy <= 1'b0;
      algoDone <= 1'b0;
    end else begin
      algoDone <= 1'b0;
      if (algoStart) begin
        busy <= 1'b1;
        cnt <= lag;
      end else if (busy && cnt == 6'h00) begin
        busy <= 1'b0;
        algoDone <= 1'b1;
      end else if (busy) begin
        cnt <= cnt - 6'h01;
      end
    end
  end
endmodule // shpio_algo_model

// ===== verification/tb.sv
// Bench of the script signal interface and output stage control.
// Assumes shortened cycle and blink counts and a modelled positioning core.
module tb import shpio_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] CDEF = 32'({DIV_RST, 3'b000, LAMPDEF_RST, 2'b00, POLICY_RST});
  logic core_clk, arst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, algoDone, algoStart;
  logic inPosStatus, ready, captureTrig;
  logic [11:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [2:0] rangeCurrent, wireBreakPin;
  logic [4:0] switchPin;
  logic [5:0] lag;
  logic [15:0] cycleTimeUs;
  logic [1:0] seen;
  shpio_val_t [4:0] anaIn, anaOut, wv;
  shpio_val_t v;
  shpio_algo_t algo;
  shpio_stage_t stage;
  shpio_lamps_t lamps;
  int compares, miscompares, cyc, caps;
  shpio_core #(.CYC_PERIOD(200), .BLINK_HALF(8)) DUT (.core_clk(core_clk), .arst_n(arst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .anaIn(anaIn), .rangeCurrent(rangeCurrent), .switchPin(switchPin),
    .wireBreakPin(wireBreakPin), .algoDone(algoDone), .inPosStatus(inPosStatus),
    .algo(algo), .algoStart(algoStart), .stage(stage), .lamps(lamps), .anaOut(anaOut),
    .ready(ready), .captureTrig(captureTrig), .cycleTimeUs(cycleTimeUs));
  shpio_algo_model PM (.core_clk(core_clk), .arst_n(arst_n), .algoStart(algoStart),
    .lag(lag), .algoDone(algoDone));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  function automatic shpio_val_t lim(shpio_val_t x, shpio_val_t lo, shpio_val_t hi);
    return (x < lo) ? lo : (x > hi) ? hi : x;
  endfunction
  function automatic shpio_val_t expIn(int k);
    // Release never set here: ready and blink read 0.0
    if (k > 9) return (k == 12 && inPosStatus) ? ON_VALUE : ZERO;
    if (k > 4) return switchPin[k - 5] ? ON_VALUE : ZERO;
    return lim(anaIn[k], k == 4 ? DIF_MIN : (k == 3 || (k < 3 && rangeCurrent[k])) ? ZERO
      : SE_MIN, SE_MAX);
  endfunction
  task automatic finish_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Classic cycle; waits on ack, the timeout cuts a hang
  task automatic bus(input logic we, input logic [11:0] adr, input logic [31:0] dat);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic put(input int i, input shpio_val_t x);
    bus(1'b1, 12'(4 * i), {16'h0000, x});
  endtask
  task automatic settle();
    repeat (450) @(posedge core_clk);
  endtask
  task automatic stageRun(input shpio_val_t aE, aL, b1, b2, bL);
    shpio_val_t a, b;
    a = lim(aL, ZERO, FULL_SCALE);
    b = lim(bL, NEG_FULL, FULL_SCALE);
    put(IDX_A_EN, aE);
    put(IDX_A_LEVEL, aL);
    put(IDX_B1_EN, b1);
    put(IDX_B2_EN, b2);
    put(IDX_B_LEVEL, bL);
    settle();
    chk(32'(stage.aOn), 32'(aE >= ON_THRESH && a != ZERO));
    chk(32'(stage.bPriOn), 32'(b1 >= ON_THRESH && b > ZERO));
    chk(32'(stage.bSecOn), 32'(b2 >= ON_THRESH && b < ZERO));
    if (aE >= ON_THRESH && a != ZERO) chk(32'(stage.aCur), 32'(a));
    if (b1 >= ON_THRESH && b > ZERO) chk(32'(stage.bPriCur), 32'(b));
    if (b2 >= ON_THRESH && b < ZERO) chk(32'(stage.bSecCur), 32'(-b));
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (captureTrig === 1'b1) caps++;
    if (cyc == 40000) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, inPosStatus, wb_adr_i, wb_dat_i} = '0;
    {anaIn, rangeCurrent, switchPin, wireBreakPin, lag} = '0;
    wb_sel_i = 4'hf;
    arst_n = 1'b0;
    void'($urandom(14));
    repeat (8) @(posedge core_clk);
    chk(32'({ready, wb_ack_o, algoStart, captureTrig}), 32'h0000_0000);
    arst_n <= 1'b1;
    @(posedge core_clk);
    bus(1'b0, ADDR_CTRL, 32'h0000_0000);
    chk(rd, CDEF);
    bus(1'b0, 12'h200, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 5; k++) begin
        anaIn[k] <= i == 0 ? 16'h8000 : i == 1 ? 16'h7fff : shpio_val_t'($urandom_range(2400))
          - shpio_val_t'(16'h04b0);
      end
      rangeCurrent <= 3'($urandom);
      switchPin <= 5'($urandom);
      inPosStatus <= 1'($urandom);
      repeat (4) @(posedge core_clk);
      for (int k = 0; k < 13; k++) begin
        bus(1'b0, ADDR_IN_BASE + 12'(4 * k), 32'h0000_0000);
        chk(32'(rd[15:0]), {16'h0000, expIn(k)});
      end
    end
    put(IDX_EXT_RELEASE, ON_VALUE);
    stageRun(16'h0009, 16'h01f4, 16'h000a, 16'h0000, 16'h0500);
    stageRun(16'h000a, 16'h0000, 16'h0000, 16'h000a, 16'hfed4);
    stageRun(16'h000a, 16'h0600, 16'h000a, 16'h0000, 16'hfed4);
    for (int i = 0; i < 5; i++) begin
      stageRun(16'($urandom_range(20)), 16'($urandom_range(1200)), 16'($urandom_range(20)),
        16'($urandom_range(20)), shpio_val_t'($urandom_range(2400)) - 16'sh04b0);
    end
    v = shpio_val_t'($urandom_range(2000));
    lag <= 6'($urandom_range(40));
    put(IDX_TARGET, v);
    put(IDX_RAW_POS, ~v);
    put(IDX_MOVE_START, ON_VALUE);
    put(IDX_SPEED, v);
    put(IDX_LOOP_RELEASE, 16'h000b);
    put(IDX_JOG_A, 16'h0009);
    put(IDX_JOG_B, ON_VALUE);
    put(IDX_SW1, ON_VALUE);
    put(IDX_SW2, 16'h0009);
    put(IDX_MID_YELLOW, 16'h7fff);
    put(IDX_RIGHT_YELLOW, 16'hfff6);
    settle();
    chk(32'(algo.target), 32'(v));
    chk(32'(algo.speed), 32'(v));
    chk(32'(algo[3:0]), 32'h0000_000d);
    chk(32'(lamps[3:0]), 32'h0000_000a);
    // Whole cycle stays under one microsecond with these lags
    chk(32'(cycleTimeUs), 32'h0000_0000);
    chk(32'(algo.rawPos), 32'(~v));
    chk(32'(algo.moveStart), 32'h0000_0001);
    for (int j = 0; j < 2; j++) begin
      for (int i = 0; i < 5; i++) begin
        wv[i] = shpio_val_t'($urandom_range(2400)) - 16'sh04b0;
        put(IDX_ANA_OUT0 + i, wv[i]);
      end
      settle();
      for (int i = 0; i < 5; i++) begin
        chk(32'(anaOut[i]), 32'(lim(wv[i], i == 2 ? NEG_FULL : ZERO, FULL_SCALE)));
      end
    end
    chk(32'({ready, lamps.green}), 32'h0000_0003);
    put(IDX_FAULT_REQ, ON_VALUE);
    settle();
    chk(32'({ready, stage.aOn, stage.bPriOn, stage.bSecOn}), 32'h0000_0000);
    seen = 2'b00;
    for (int i = 0; i < 16; i++) begin
      bus(1'b0, ADDR_STAT, 32'h0000_0000);
      seen = seen | (rd[STAT_BLINK_BIT] ? 2'b10 : 2'b01);
    end
    chk(32'(rd[STAT_SCRIPT_FAULT_REQUEST_BIT]), 32'h0000_0001);
    chk(32'(seen), 32'h0000_0003);
    put(IDX_FAULT_REQ, 16'h0009);
    settle();
    chk(32'(ready), 32'h0000_0000);
    bus(1'b1, ADDR_CTRL, CDEF | 32'h0001_0000);
    settle();
    chk(32'(ready), 32'h0000_0001);
    put(IDX_A_EN, ON_VALUE);
    put(IDX_A_LEVEL, 16'h0200);
    settle();
    wireBreakPin <= 3'b001;
    repeat (6) @(posedge core_clk);
    chk(32'({ready, stage.aOn}), 32'h0000_0000);
    bus(1'b0, ADDR_STAT, 32'h0000_0000);
    chk(32'(rd[4:0]), 32'h0000_0004);
    wireBreakPin <= 3'b000;
    bus(1'b1, ADDR_CTRL, CDEF | 32'h0001_0000);
    put(IDX_A_EN, ZERO);
    settle();
    wireBreakPin <= 3'b001;
    repeat (6) @(posedge core_clk);
    chk(32'(ready), 32'h0000_0001);
    chk(32'(caps), 32'h0000_0000);
    put(IDX_CAPTURE, ON_VALUE);
    settle();
    chk(32'(caps > 0), 32'h0000_0001);
    bus(1'b0, ADDR_CAPTURE_TRIGGER_BASE, 32'h0000_0000);
    chk(32'(rd[15:0]), 32'h0000_0200);
    finish_test();
  end
endmodule // tb
